//--- hw/trigger_pause_control.sv
// trigger, pause and halt control of the vector sequencer, with aux clock source
`timescale 1ns/10ps
// How it works
// - software trigger enters Run at once, first
// - low external trigger line enters Run
// - external trigger beats other trigger conditions
// - masked event lines compared with two patterns
// - one level: either pattern match triggers
// - two level: both patterns in sequence trigger
// - selectable, enableable PXI line triggers
// - software pause enters Pause at once, first
// - low external pause line pauses after the pin synchroniser delay
// - external pause beats other pause conditions
// - masked event lines matched against hold pattern
// - selectable, enableable PXI line pauses
// - software word can replace event lines
// - programmable independent aux clock output
// - aux clock undefined at power-up, survives reset
// - reset and halt give Halt, counter zero
// - in Halt external inputs are ignored
// - arm leaves Halt, pause leaves Run
module trigger_pause_control
  import trig_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rd_data_o,
  input wire logic [EVENT_W-1:0] event_i,
  input wire logic ext_trig_n_i,
  input wire logic ext_pause_n_i,
  input wire logic [PXI_W-1:0] pxi_trig_i,
  output seq_state_t state_o,
  output logic [PC_W-1:0] pc_o,
  output logic aux_freq_source_o
);

  function automatic logic ev_match(input logic [EVENT_W-1:0] ev,
                                    input logic [EVENT_W-1:0] mask,
                                    input logic [EVENT_W-1:0] pat);
    ev_match = ((ev & mask) == (pat & mask));
  endfunction

  ctrl_t ctrl_q;
  logic [EVENT_W-1:0] trig_mask_q;
  logic [EVENT_W-1:0] primary_q;
  logic [EVENT_W-1:0] secondary_q;
  logic [EVENT_W-1:0] hold_mask_q;
  logic [EVENT_W-1:0] hold_match_q;
  logic [EVENT_W-1:0] soft_event_q;
  logic [AUX_DIV_W-1:0] aux_div_q;
  logic [AUX_DIV_W-1:0] aux_cnt_q;
  logic aux_clk_q;
  seq_state_t state_q;
  seq_state_t state_d;
  logic [PC_W-1:0] pc_q;
  logic level1_q;
  logic first_pri_q;
  logic [DATA_W-1:0] rd_data_q;

  logic [EVENT_W-1:0] event_sync;
  logic ext_trig_n_sync;
  logic ext_pause_n_sync;
  logic [PXI_W-1:0] pxi_sync;
  logic [EVENT_W-1:0] ev_src;
  logic cmd_wr;
  logic arm_cmd;
  logic trig_cmd;
  logic pause_cmd;
  logic halt_cmd;
  logic ext_trig;
  logic ext_pause;
  logic pri_hit;
  logic sec_hit;
  logic hold_hit;
  logic evt_trig_hit;
  logic evt_pause_hit;
  logic pxi_trig_hit;
  logic pxi_pause_hit;

  pin_sync #(.WIDTH(EVENT_W), .RST_VAL(16'h0000)) u_event_sync (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .pin_i(event_i),
    .level_o(event_sync)
  );

  pin_sync #(.WIDTH(2), .RST_VAL(2'h3)) u_ctl_sync (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .pin_i({ext_pause_n_i, ext_trig_n_i}),
    .level_o({ext_pause_n_sync, ext_trig_n_sync})
  );

  pin_sync #(.WIDTH(PXI_W), .RST_VAL(8'h00)) u_pxi_sync (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .pin_i(pxi_trig_i),
    .level_o(pxi_sync)
  );

  // command decode
  assign cmd_wr = wr_i && (addr_i == CMD_OFS);
  assign arm_cmd = cmd_wr && wr_data_i[CMD_ARM_BIT];
  assign trig_cmd = cmd_wr && wr_data_i[CMD_TRIG_BIT];
  assign pause_cmd = cmd_wr && wr_data_i[CMD_PAUSE_BIT];
  assign halt_cmd = cmd_wr && wr_data_i[CMD_HALT_BIT];

  // condition sources
  assign ev_src = ctrl_q.use_soft ? soft_event_q : event_sync;
  assign ext_trig = !ext_trig_n_sync;
  assign ext_pause = !ext_pause_n_sync;
  assign pri_hit = ev_match(ev_src, trig_mask_q, primary_q);
  assign sec_hit = ev_match(ev_src, trig_mask_q, secondary_q);
  assign hold_hit = ev_match(ev_src, hold_mask_q, hold_match_q);
  assign evt_pause_hit = ctrl_q.evt_pause_en && hold_hit;
  assign pxi_trig_hit = ctrl_q.pxi_trig_en && pxi_sync[ctrl_q.trig_sel];
  assign pxi_pause_hit = ctrl_q.pxi_pause_en && pxi_sync[ctrl_q.pause_sel];

  always_comb
  begin
    evt_trig_hit = 1'b0;
    if (ctrl_q.evt_trig_en)
    begin
      if (ctrl_q.two_level)
      begin
        evt_trig_hit = level1_q && (first_pri_q ? sec_hit : pri_hit);
      end
      else
      begin
        evt_trig_hit = pri_hit || sec_hit;
      end
    end
  end

  // sequencer state, software commands first, then pins, then conditions
  always_comb
  begin
    state_d = state_q;
    if (halt_cmd)
    begin
      state_d = ST_HALT;
    end
    else if (pause_cmd && (state_q == ST_RUN))
    begin
      state_d = ST_PAUSE;
    end
    else if (trig_cmd && (state_q != ST_RUN))
    begin
      state_d = ST_RUN;
    end
    else if (arm_cmd && (state_q == ST_HALT))
    begin
      state_d = ST_PAUSE;
    end
    else
    begin
      case (state_q)
        ST_RUN:
        begin
          if (ext_pause)
          begin
            state_d = ST_PAUSE;
          end
          else if (evt_pause_hit || pxi_pause_hit)
          begin
            state_d = ST_PAUSE;
          end
        end
        ST_PAUSE:
        begin
          if (ext_trig)
          begin
            state_d = ST_RUN;
          end
          else if (evt_trig_hit || pxi_trig_hit)
          begin
            state_d = ST_RUN;
          end
        end
        ST_HALT:
        begin
          state_d = ST_HALT;
        end
        default:
        begin
          state_d = ST_HALT;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q <= ST_HALT;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // program counter
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pc_q <= '0;
    end
    else if (halt_cmd)
    begin
      pc_q <= '0;
    end
    else if (state_q == ST_RUN)
    begin
      pc_q <= pc_q + 16'h0001;
    end
  end

  // first level of the two-level event trigger
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      level1_q <= 1'b0;
      first_pri_q <= 1'b0;
    end
    else if ((state_d != ST_PAUSE) || !ctrl_q.two_level || !ctrl_q.evt_trig_en)
    begin
      level1_q <= 1'b0;
    end
    else if (!level1_q && (pri_hit || sec_hit))
    begin
      level1_q <= 1'b1;
      first_pri_q <= pri_hit;
    end
  end

  // configuration registers
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= CTRL_RST;
      trig_mask_q <= MASK_RST;
      primary_q <= PATTERN_RST;
      secondary_q <= PATTERN_RST;
      hold_mask_q <= MASK_RST;
      hold_match_q <= PATTERN_RST;
      soft_event_q <= PATTERN_RST;
    end
    else if (wr_i)
    begin
      case (addr_i)
        CTRL_OFS: ctrl_q <= wr_data_i[CTRL_W-1:0];
        TRIG_MASK_OFS: trig_mask_q <= wr_data_i[EVENT_W-1:0];
        PRIMARY_OFS: primary_q <= wr_data_i[EVENT_W-1:0];
        SECONDARY_OFS: secondary_q <= wr_data_i[EVENT_W-1:0];
        HOLD_MASK_OFS: hold_mask_q <= wr_data_i[EVENT_W-1:0];
        HOLD_MATCH_OFS: hold_match_q <= wr_data_i[EVENT_W-1:0];
        SOFT_EVENT_OFS: soft_event_q <= wr_data_i[EVENT_W-1:0];
        default: ;
      endcase
    end
  end

  // aux clock divider, deliberately without reset
  always_ff @(posedge sys_clk_i)
  begin
    if (wr_i && (addr_i == AUX_DIV_OFS))
    begin
      aux_div_q <= wr_data_i[AUX_DIV_W-1:0];
      aux_cnt_q <= '0;
      aux_clk_q <= 1'b0;
    end
    else if (aux_cnt_q == aux_div_q)
    begin
      aux_cnt_q <= '0;
      aux_clk_q <= !aux_clk_q;
    end
    else
    begin
      aux_cnt_q <= aux_cnt_q + 8'h01;
    end
  end

  // read data, valid only in the cycle after the strobe
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rd_data_q <= '0;
    end
    else if (rd_i)
    begin
      case (addr_i)
        CTRL_OFS: rd_data_q <= {20'h00000, ctrl_q};
        TRIG_MASK_OFS: rd_data_q <= {16'h0000, trig_mask_q};
        PRIMARY_OFS: rd_data_q <= {16'h0000, primary_q};
        SECONDARY_OFS: rd_data_q <= {16'h0000, secondary_q};
        HOLD_MASK_OFS: rd_data_q <= {16'h0000, hold_mask_q};
        HOLD_MATCH_OFS: rd_data_q <= {16'h0000, hold_match_q};
        SOFT_EVENT_OFS: rd_data_q <= {16'h0000, soft_event_q};
        AUX_DIV_OFS: rd_data_q <= {24'h000000, aux_div_q};
        STATUS_OFS: rd_data_q <= {26'h0000000, ext_pause, ext_trig, first_pri_q,
                                  level1_q, state_q};
        PC_OFS: rd_data_q <= {16'h0000, pc_q};
        EVENT_OFS: rd_data_q <= {16'h0000, event_sync};
        default: rd_data_q <= '0;
      endcase
    end
    else
    begin
      rd_data_q <= '0;
    end
  end

  assign rd_data_o = rd_data_q;
  assign state_o = state_q;
  assign pc_o = pc_q;
  assign aux_freq_source_o = aux_clk_q;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_pin_trig;
    (!ext_trig_n_i)[*5] ##1
      (!ext_trig_n_i && !cmd_wr && (state_q == ST_PAUSE));
  endsequence

  sequence s_first_level;
    (state_q == ST_PAUSE) && ctrl_q.two_level && ctrl_q.evt_trig_en && !level1_q
      && pri_hit && !sec_hit && !cmd_wr && !wr_i && !ext_trig && !pxi_trig_hit;
  endsequence

  sequence s_second_level;
    (state_q == ST_PAUSE) && sec_hit && !cmd_wr;
  endsequence

  sw_trig_run_a: assert property (
    trig_cmd && !halt_cmd && !pause_cmd && (state_q != ST_RUN) |=> state_q == ST_RUN)
    else $error("software trigger did not enter run");

  ext_trig_run_a: assert property (
    (state_q == ST_PAUSE) && ext_trig && !cmd_wr |=> state_q == ST_RUN)
    else $error("external trigger did not enter run");

  pin_trig_run_a: assert property (
    s_pin_trig |=> state_q == ST_RUN)
    else $error("held trigger pin did not win");

  single_level_a: assert property (
    (state_q == ST_PAUSE) && !cmd_wr && ctrl_q.evt_trig_en && !ctrl_q.two_level
      && (pri_hit || sec_hit) |=> state_q == ST_RUN)
    else $error("single level match did not trigger");

  two_level_a: assert property (
    s_first_level ##1 s_second_level |=> state_q == ST_RUN)
    else $error("two level sequence did not trigger");

  no_early_a: assert property (
    s_first_level |=> state_q == ST_PAUSE)
    else $error("two level triggered on first match");

  pxi_trig_a: assert property (
    (state_q == ST_PAUSE) && !cmd_wr && ctrl_q.pxi_trig_en
      && pxi_sync[ctrl_q.trig_sel] |=> state_q == ST_RUN)
    else $error("pxi line did not trigger");

  sw_pause_a: assert property (
    pause_cmd && !halt_cmd && (state_q == ST_RUN) |=> state_q == ST_PAUSE)
    else $error("software pause did not pause");

  ext_pause_a: assert property (
    (state_q == ST_RUN) && ext_pause && !cmd_wr |=> state_q == ST_PAUSE)
    else $error("external pause did not pause");

  hold_match_a: assert property (
    (state_q == ST_RUN) && !cmd_wr && ctrl_q.evt_pause_en
      && ev_match(ev_src, hold_mask_q, hold_match_q) |=> state_q == ST_PAUSE)
    else $error("hold match did not pause");

  pxi_pause_a: assert property (
    (state_q == ST_RUN) && !cmd_wr && ctrl_q.pxi_pause_en
      && pxi_sync[ctrl_q.pause_sel] |=> state_q == ST_PAUSE)
    else $error("pxi line did not pause");

  halt_clear_a: assert property (
    halt_cmd |=> (state_q == ST_HALT) && (pc_q == 16'h0000))
    else $error("halt did not clear state and counter");

  halt_quiet_a: assert property (
    (state_q == ST_HALT) && !cmd_wr |=> state_q == ST_HALT)
    else $error("halt left without a command");

  arm_pause_a: assert property (
    arm_cmd && !halt_cmd && !trig_cmd && (state_q == ST_HALT) |=> state_q == ST_PAUSE)
    else $error("arm did not enter pause");

endmodule

//--- inc/trig_pkg.sv
// constants, types and register map of the trigger and pause control block
package trig_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned EVENT_W = 16;
  localparam int unsigned PXI_W = 8;
  localparam int unsigned PXI_SEL_W = 3;
  localparam int unsigned PC_W = 16;
  localparam int unsigned AUX_DIV_W = 8;
  localparam int unsigned SYNC_STAGES = 3;

  // register byte offsets
  localparam logic [ADDR_W-1:0] CMD_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] TRIG_MASK_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] PRIMARY_OFS = 8'h0c;
  localparam logic [ADDR_W-1:0] SECONDARY_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] HOLD_MASK_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] HOLD_MATCH_OFS = 8'h18;
  localparam logic [ADDR_W-1:0] SOFT_EVENT_OFS = 8'h1c;
  localparam logic [ADDR_W-1:0] AUX_DIV_OFS = 8'h20;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h24;
  localparam logic [ADDR_W-1:0] PC_OFS = 8'h28;
  localparam logic [ADDR_W-1:0] EVENT_OFS = 8'h2c;

  // command register bit positions
  localparam int unsigned CMD_ARM_BIT = 0;
  localparam int unsigned CMD_TRIG_BIT = 1;
  localparam int unsigned CMD_PAUSE_BIT = 2;
  localparam int unsigned CMD_HALT_BIT = 3;

  // control register layout, low bit is two_level
  typedef struct packed {
    logic [PXI_SEL_W-1:0] pause_sel;
    logic [PXI_SEL_W-1:0] trig_sel;
    logic pxi_pause_en;
    logic pxi_trig_en;
    logic evt_pause_en;
    logic evt_trig_en;
    logic use_soft;
    logic two_level;
  } ctrl_t;
  localparam int unsigned CTRL_W = $bits(ctrl_t);
  localparam logic [CTRL_W-1:0] CTRL_RST = 12'h000;

  localparam logic [EVENT_W-1:0] MASK_RST = 16'h0000;
  localparam logic [EVENT_W-1:0] PATTERN_RST = 16'h0000;

  // aux clock: f = SYS_CLK_HZ / (2 * (div + 1))
  localparam int unsigned SYS_CLK_HZ = 100_000_000;
  localparam int unsigned AUX_MIN_HZ = 1_000_000;
  localparam int unsigned AUX_MAX_HZ = 200_000_000;

  typedef enum logic [1:0] {
    ST_HALT = 2'b00,
    ST_PAUSE = 2'b01,
    ST_RUN = 2'b10
  } seq_state_t;

endpackage

//--- hw/pin_sync.sv
// three-stage pin synchroniser, output changes once stages two and three agree
`timescale 1ns/10ps
module pin_sync
  import trig_pkg::*;
#(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] level_q;

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
    end
    else
    begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // per bit: accept only when stage two and three agree
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      level_q <= RST_VAL;
    end
    else
    begin
      level_q <= (s2_q & s3_q) | (level_q & (s2_q | s3_q));
    end
  end

  assign level_o = level_q;

endmodule

//--- testbench/uut_model.sv
// behavioural unit under test driving event, control and trigger bus lines
`timescale 1ns/10ps
module uut_model
  import trig_pkg::*;
(
  input wire logic sys_clk_i,
  output logic [EVENT_W-1:0] event_o,
  output logic ext_trig_n_o,
  output logic ext_pause_n_o,
  output logic [PXI_W-1:0] pxi_trig_o
);
  // idle: control lines high, events and bus lines low
  initial
  begin
    event_o = 16'h0000;
    ext_trig_n_o = 1'b1;
    ext_pause_n_o = 1'b1;
    pxi_trig_o = 8'h00;
  end

  // all lines change together just after a rising edge
  task automatic drive(input logic [EVENT_W-1:0] ev, input logic tn, input logic pn,
    input logic [PXI_W-1:0] px);
    @(posedge sys_clk_i);
    event_o <= ev;
    ext_trig_n_o <= tn;
    ext_pause_n_o <= pn;
    pxi_trig_o <= px;
  endtask
endmodule

//--- testbench/testbench.sv
// self-checking bench for trigger and pause control
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module testbench
  import trig_pkg::*;
;
  logic sys_clk_i;
  logic rst_i;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wr_data_i;
  logic wr_i;
  logic rd_i;
  logic [DATA_W-1:0] rd_data_o;
  logic [EVENT_W-1:0] event_i;
  logic ext_trig_n_i;
  logic ext_pause_n_i;
  logic [PXI_W-1:0] pxi_trig_i;
  seq_state_t state_o;
  logic [PC_W-1:0] pc_o;
  logic aux_freq_source_o;
  int n_mismatch;
  int checks_done;
  int aux_cnt;

  trigger_pause_control trigger_pause_control_i (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .event_i(event_i),
    .ext_trig_n_i(ext_trig_n_i), .ext_pause_n_i(ext_pause_n_i), .pxi_trig_i(pxi_trig_i),
    .state_o(state_o), .pc_o(pc_o), .aux_freq_source_o(aux_freq_source_o));

  uut_model uut_model_i (
    .sys_clk_i(sys_clk_i), .event_o(event_i), .ext_trig_n_o(ext_trig_n_i),
    .ext_pause_n_o(ext_pause_n_i), .pxi_trig_o(pxi_trig_i));

  initial
  begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge aux_freq_source_o)
    aux_cnt++;

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string nm);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    `CHK(nm, e, rd_data_o)
  endtask

  // command write, new state seen right after the write edge
  task automatic cmd(input int b, input seq_state_t e);
    wr(CMD_OFS, 32'h1 << b);
    #1;
    `CHK("state after command", e, state_o)
  endtask

  // stay: state checked once after 10 cycles; else wait at most 12 cycles for it
  task automatic st(input seq_state_t e, input bit stay);
    int i;
    i = 0;
    #1;
    if (stay)
      repeat (10) @(posedge sys_clk_i);
    else
      while (state_o !== e && i < 12)
      begin
        @(posedge sys_clk_i);
        #1;
        i++;
      end
    #1;
    `CHK("state", e, state_o)
  endtask

  // f: 0 two_level, 1 use_soft, 2 evt_trig, 3 evt_pause, 4 pxi_trig, 5 pxi_pause
  function automatic logic [DATA_W-1:0] cw(input logic [5:0] f, input logic [2:0] ts,
    input logic [2:0] ps);
    ctrl_t c;
    c = ctrl_t'{ps, ts, f[5], f[4], f[3], f[2], f[1], f[0]};
    return DATA_W'(c);
  endfunction

  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    n_mismatch++;
    results();
  end

  initial
  begin
    logic [PC_W-1:0] p;
    rst_i = 1'b1;
    addr_i = 8'h00;
    wr_data_i = 32'h0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    n_mismatch = 0;
    checks_done = 0;
    aux_cnt = 0;
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    #1;
    `CHK("state at reset", ST_HALT, state_o)
    `CHK("pc at reset", 16'h0000, pc_o)
    rd(CTRL_OFS, 32'h0, "ctrl reset");
    wr(8'h3c, 32'h1234_5678);
    rd(8'h3c, 32'h0, "unmapped");
    rd(CMD_OFS, 32'h0, "cmd read");
    uut_model_i.drive(16'h0000, 1'b0, 1'b1, 8'h00);
    st(ST_HALT, 1);
    cmd(CMD_ARM_BIT, ST_PAUSE);
    st(ST_RUN, 0);
    cmd(CMD_HALT_BIT, ST_HALT);
    uut_model_i.drive(16'h0000, 1'b1, 1'b1, 8'h00);
    repeat (8) @(posedge sys_clk_i);
    cmd(CMD_ARM_BIT, ST_PAUSE);
    uut_model_i.drive(16'h0000, 1'b0, 1'b1, 8'h00);
    st(ST_RUN, 0);
    p = pc_o;
    repeat (4) @(posedge sys_clk_i);
    #1;
    `CHK("pc count", p + 16'h0004, pc_o)
    uut_model_i.drive(16'h0000, 1'b1, 1'b0, 8'h00);
    st(ST_PAUSE, 0);
    uut_model_i.drive(16'h0000, 1'b1, 1'b1, 8'h00);
    repeat (8) @(posedge sys_clk_i);
    cmd(CMD_TRIG_BIT, ST_RUN);
    cmd(CMD_PAUSE_BIT, ST_PAUSE);
    cmd(CMD_HALT_BIT, ST_HALT);
    cmd(CMD_TRIG_BIT, ST_RUN);
    wr(CMD_OFS, 32'h0000_000f);
    #1;
    `CHK("halt wins", ST_HALT, state_o)
    rd(PC_OFS, 32'h0, "pc after halt");
    rd(STATUS_OFS, 32'h0, "status in halt");
    wr(TRIG_MASK_OFS, 32'h0000_00ff);
    wr(PRIMARY_OFS, 32'h0000_12ab);
    wr(SECONDARY_OFS, 32'h0000_0034);
    rd(PRIMARY_OFS, 32'h0000_12ab, "primary");
    wr(CTRL_OFS, cw(6'b000100, 3'd0, 3'd0));
    cmd(CMD_ARM_BIT, ST_PAUSE);
    uut_model_i.drive(16'h55ac, 1'b1, 1'b1, 8'h00);
    st(ST_PAUSE, 1);
    rd(EVENT_OFS, 32'h0000_55ac, "event lines");
    uut_model_i.drive(16'h55ab, 1'b1, 1'b1, 8'h00);
    st(ST_RUN, 0);
    cmd(CMD_HALT_BIT, ST_HALT);
    uut_model_i.drive(16'hff34, 1'b1, 1'b1, 8'h00);
    st(ST_HALT, 1);
    cmd(CMD_ARM_BIT, ST_PAUSE);
    st(ST_RUN, 0);
    cmd(CMD_HALT_BIT, ST_HALT);
    wr(CTRL_OFS, cw(6'b000101, 3'd0, 3'd0));
    uut_model_i.drive(16'h00ab, 1'b1, 1'b1, 8'h00);
    repeat (6) @(posedge sys_clk_i);
    cmd(CMD_ARM_BIT, ST_PAUSE);
    st(ST_PAUSE, 1);
    uut_model_i.drive(16'h0034, 1'b1, 1'b1, 8'h00);
    st(ST_RUN, 0);
    cmd(CMD_HALT_BIT, ST_HALT);
    uut_model_i.drive(16'h008b, 1'b1, 1'b1, 8'h00);
    repeat (6) @(posedge sys_clk_i);
    cmd(CMD_ARM_BIT, ST_PAUSE);
    st(ST_PAUSE, 1);
    uut_model_i.drive(16'h00ab, 1'b1, 1'b1, 8'h00);
    uut_model_i.drive(16'h0034, 1'b1, 1'b1, 8'h00);
    st(ST_RUN, 0);
    cmd(CMD_HALT_BIT, ST_HALT);
    repeat (6) @(posedge sys_clk_i);
    cmd(CMD_ARM_BIT, ST_PAUSE);
    st(ST_PAUSE, 1);
    uut_model_i.drive(16'h00ab, 1'b1, 1'b1, 8'h00);
    st(ST_RUN, 0);
    cmd(CMD_HALT_BIT, ST_HALT);
    wr(HOLD_MASK_OFS, 32'h0000_0f00);
    wr(HOLD_MATCH_OFS, 32'h0000_0300);
    wr(SOFT_EVENT_OFS, 32'h0000_0034);
    rd(SOFT_EVENT_OFS, 32'h0000_0034, "soft event");
    wr(CTRL_OFS, cw(6'b001110, 3'd0, 3'd0));
    uut_model_i.drive(16'h0000, 1'b1, 1'b1, 8'h00);
    cmd(CMD_ARM_BIT, ST_PAUSE);
    st(ST_RUN, 0);
    wr(SOFT_EVENT_OFS, 32'h0000_0335);
    st(ST_PAUSE, 0);
    for (int s = 0; s < 8; s++)
    begin
      cmd(CMD_HALT_BIT, ST_HALT);
      wr(CTRL_OFS, cw(6'b110000, 3'(s), 3'(s + 1)));
      uut_model_i.drive(16'h0000, 1'b1, 1'b1, 8'h01 << ((s + 1) % 8));
      repeat (6) @(posedge sys_clk_i);
      cmd(CMD_ARM_BIT, ST_PAUSE);
      st(ST_PAUSE, 1);
      uut_model_i.drive(16'h0000, 1'b1, 1'b1, 8'h01 << s);
      st(ST_RUN, 0);
      uut_model_i.drive(16'h0000, 1'b1, 1'b1, 8'h01 << ((s + 1) % 8));
      st(ST_PAUSE, 0);
    end
    cmd(CMD_HALT_BIT, ST_HALT);
    wr(CTRL_OFS, cw(6'b100000, 3'd0, 3'd1));
    uut_model_i.drive(16'h0000, 1'b1, 1'b1, 8'h01);
    cmd(CMD_ARM_BIT, ST_PAUSE);
    st(ST_PAUSE, 1);
    wr(AUX_DIV_OFS, 32'h0000_0004);
    repeat (4) @(posedge sys_clk_i);
    #1 aux_cnt = 0;
    repeat (100) @(posedge sys_clk_i);
    `CHK("aux edges", 1'b1, (aux_cnt >= 9 && aux_cnt <= 11))
    #1 aux_cnt = 0;
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    repeat (20) @(posedge sys_clk_i);
    #1;
    `CHK("aux in reset", 1'b1, (aux_cnt >= 1))
    `CHK("state in reset", ST_HALT, state_o)
    @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd(AUX_DIV_OFS, 32'h0000_0004, "aux setting kept");
    rd(CTRL_OFS, 32'h0, "ctrl after reset");
    `CHK("pc after reset", 16'h0000, pc_o)
    results();
  end
endmodule
